/* File: fbc_map.svh */
// register offsets, field positions, lookup tables and frame constants
`ifndef FBC_MAP_SVH
`define FBC_MAP_SVH
// ==========================================================
// register offsets
`define FBC_ADDR_PTR 5'h00
`define FBC_ADDR_CTRL 5'h01
`define FBC_ADDR_COARSE 5'h02
`define FBC_ADDR_FINE 5'h03
`define FBC_ADDR_CAL 5'h04
`define FBC_ADDR_PERIOD 5'h05
`define FBC_ADDR_SETTING 5'h06
`define FBC_ADDR_STATUS 5'h08
`define FBC_ADDR_RESULT 5'h09
`define FBC_ADDR_OTP_MODE 5'h0B
`define FBC_ADDR_OTP_ADDR 5'h0C
`define FBC_ADDR_OTP_STROBE 5'h0D
// ==========================================================
// field positions
`define FBC_CTRL_CAL_EN 1
`define FBC_CTRL_DOUBLER 2
`define FBC_CTRL_APPLY 4
`define FBC_CTRL_CH_I_EN 6
`define FBC_CTRL_CH_Q_EN 7
`define FBC_COARSE_LSB 6
`define FBC_STAT_BUSY 4
`define FBC_STAT_OTP_BUSY 5
`define FBC_PERIOD_MSB 14
`define FBC_SETTING_MSB 8
// ==========================================================
// frame and reset constants
`define FBC_CHIP_ID 3'h5
`define FBC_FRAME_BITS 6'h20
`define FBC_CNT_SAT 6'h3F
`define FBC_REG_RESET 24'h000000
`define FBC_MAX_COARSE 4'h8
`define FBC_MAX_FINE 4'hB
`define FBC_BW_RST_CORNER 7'h05
`define FBC_BW_RST_RATIO 11'h323
// ==========================================================
// lookup tables, entry 0 in the low bits
`define FBC_CORNER_TBL {7'h48, 7'h32, 7'h28, 7'h1C, 7'h14, 7'h0E, \
   7'h0A, 7'h07, 7'h05}
`define FBC_RATIO_TBL {11'h49F, 11'h470, 11'h449, 11'h427, 11'h406, \
   11'h3E2, 11'h3BF, 11'h39E, 11'h37D, 11'h35E, 11'h340, 11'h323}
// measurement bounds between adjacent fine codes
`define FBC_FINE_THR {24'hB46A86, 24'hAE3EB8, 24'hA83B6C, 24'hA37C30, \
   24'h9DC9E8, 24'h9817A0, 24'h92DEDE, 24'h8D7D9A, 24'h8895DC, \
   24'h83859C, 24'h7F1764}
`endif

/* File: fbc_pkg.sv */
// types shared by the bandwidth and calibration control block
package fbc_pkg;
   typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_MEASURE} fbc_state_t;
   typedef struct packed {
      logic sen_n;
      logic sck;
      logic sdi;
      logic cal_ref;
      logic trip;
   } fbc_pins_t;
   typedef struct packed {
      logic programmed;
      logic busy;
      logic [3:0] coarse;
      logic [3:0] fine;
   } fbc_otp_t;
   typedef struct packed {
      logic [3:0] coarse;
      logic [3:0] fine;
      logic [6:0] corner_mhz;
      logic [10:0] ratio_milli;
   } fbc_bw_t;
   typedef struct packed {
      logic [4:0] ptr;
      logic [23:0] ctrl;
      logic [23:0] coarse;
      logic [23:0] fine;
      logic [23:0] period;
      logic [23:0] setting;
      logic otp_mode;
      logic [3:0] otp_addr;
      logic otp_wr;
   } fbc_regs_t;
   typedef struct packed {
      logic sck_d;
      logic sen_d;
      logic [5:0] cnt;
      logic [31:0] rx;
      logic [31:0] tx;
      logic sdo;
      logic addressed;
   } fbc_spi_t;
   typedef struct packed {
      fbc_state_t state;
      logic cal_ref_d;
      logic [8:0] edges;
      logic [23:0] acc;
      logic [23:0] result;
      logic [3:0] code;
   } fbc_cal_t;
endpackage

/* File: fbc_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fbc_sync #(parameter int W = 1)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta <= '0;
         q_o <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

/* File: fbc_fine_pick.sv */
// maps an rc measurement onto the nearest fine bandwidth code
`timescale 1ns/1ps
`include "fbc_map.svh"
module fbc_fine_pick
(
   input wire logic [23:0] result_i,
   output logic [3:0] code_o
);
   localparam logic [263:0] THR = `FBC_FINE_THR;
   // a slow rc needs a wider ratio, so each bound passed adds one code
   always_comb
   begin
      code_o = 4'h0;
      for (int i = 0; i < 11; i++)
      begin
         if (result_i >= THR[i*24 +: 24])
         begin
            code_o = code_o + 4'h1;
         end
      end
   end
endmodule

/* File: fbc_ctrl.sv */
// bandwidth selection and rc calibration control behind the serial port
`timescale 1ns/1ps
`include "fbc_map.svh"
// Contract
// - measurement result readable as 24-bit field
// - coarse codes 0-8 decode to corners
// - fine codes 0-11 decode to ratios
// - new codes used only after apply bit, except a calibration result, which loads the active fine code at once
// - writing zero to start register calibrates
// - busy status high while calibration runs
// - result code in status, copied to fine
// - later host fine write overrides calibration
// - stored codes readable at calibration register
// - bias follows its channel enable
// - otp writable through serial port
module fbc_ctrl
(
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic SPI_EN_N_I,
   input wire logic SPI_CLK_I,
   input wire logic SPI_DATA_I,
   output logic SPI_DATA_O,
   output logic SPI_DATA_OE_O,
   input wire logic CALIBRATION_REFERENCE_CLOCK_I,
   input wire logic RC_TRIP_I,
   output logic RC_CHARGE_O,
   output logic CLK_DOUBLER_EN_O,
   input wire fbc_pkg::fbc_otp_t OTP_STRAP_I,
   output logic OTP_WRITE_O,
   output logic [3:0] OTP_BIT_ADDR_O,
   output fbc_pkg::fbc_bw_t BW_O,
   output logic CH_I_EN_O,
   output logic CH_Q_EN_O,
   output logic BIAS_I_EN_O,
   output logic BIAS_Q_EN_O
);
   import fbc_pkg::*;

   // ==========================================================
   // pin synchronisers
   fbc_pins_t pins_raw;
   fbc_pins_t pins;
   fbc_otp_t otp;
   assign pins_raw = '{sen_n: SPI_EN_N_I, sck: SPI_CLK_I, sdi: SPI_DATA_I,
      cal_ref: CALIBRATION_REFERENCE_CLOCK_I, trip: RC_TRIP_I};

   fbc_sync #(.W($bits(fbc_pins_t))) u_pin_sync
   (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .d_i(pins_raw),
      .q_o(pins)
   );

   fbc_sync #(.W($bits(fbc_otp_t))) u_otp_sync
   (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .d_i(OTP_STRAP_I),
      .q_o(otp)
   );

   // ==========================================================
   // state
   fbc_regs_t r;
   fbc_regs_t next_r;
   fbc_spi_t spi;
   fbc_spi_t next_spi;
   fbc_cal_t cal;
   fbc_cal_t next_cal;
   fbc_bw_t bw;
   fbc_bw_t next_bw;
   logic [3:0] pick_code;
   logic [23:0] rd_data;
   logic [23:0] wr_data;
   logic [4:0] wr_addr;
   logic wr;
   logic sck_rise;
   logic sen_fall;
   logic sen_rise;
   logic cal_edge;
   logic cal_start;
   logic cal_done;
   logic [23:0] step;

   fbc_fine_pick u_pick
   (
      .result_i(cal.acc),
      .code_o(pick_code)
   );

   function automatic logic [6:0] corner_of(input logic [3:0] c);
      logic [62:0] t;
      t = `FBC_CORNER_TBL;
      return (c <= `FBC_MAX_COARSE) ? t[c*7 +: 7] : 7'h00;
   endfunction

   function automatic logic [10:0] ratio_of(input logic [3:0] f);
      logic [131:0] t;
      t = `FBC_RATIO_TBL;
      return (f <= `FBC_MAX_FINE) ? t[f*11 +: 11] : 11'h000;
   endfunction

   // ==========================================================
   // serial frame decode
   assign sck_rise = pins.sck && !spi.sck_d;
   assign sen_fall = !pins.sen_n && spi.sen_d;
   assign sen_rise = pins.sen_n && !spi.sen_d;
   // frames of the wrong length or chip id leave the registers alone
   assign wr = sen_rise && (spi.cnt == `FBC_FRAME_BITS)
      && (spi.rx[2:0] == `FBC_CHIP_ID);
   assign wr_data = spi.rx[31:8];
   assign wr_addr = spi.rx[7:3];

   always_comb
   begin
      rd_data = 24'h000000;
      if (r.ptr == `FBC_ADDR_PTR)
         rd_data = {19'h00000, r.ptr};
      else if (r.ptr == `FBC_ADDR_CTRL)
         rd_data = r.ctrl;
      else if (r.ptr == `FBC_ADDR_COARSE)
         rd_data = r.coarse;
      else if (r.ptr == `FBC_ADDR_FINE)
         rd_data = r.fine;
      else if (r.ptr == `FBC_ADDR_CAL)
      begin
         if (otp.programmed)
            rd_data = {14'h0000, otp.coarse, 2'h0, otp.fine};
         else
            rd_data = {14'h0000, r.coarse[9:6], 2'h0, r.fine[3:0]};
      end
      else if (r.ptr == `FBC_ADDR_PERIOD)
         rd_data = r.period;
      else if (r.ptr == `FBC_ADDR_SETTING)
         rd_data = r.setting;
      else if (r.ptr == `FBC_ADDR_STATUS)
         rd_data = {18'h00000, otp.busy, cal.state != CAL_IDLE, cal.code};
      else if (r.ptr == `FBC_ADDR_RESULT)
         rd_data = cal.result;
      else if (r.ptr == `FBC_ADDR_OTP_MODE)
         rd_data = {23'h000000, r.otp_mode};
      else if (r.ptr == `FBC_ADDR_OTP_ADDR)
         rd_data = {20'h00000, r.otp_addr};
   end

   always_comb
   begin
      next_spi = spi;
      next_spi.sck_d = pins.sck;
      next_spi.sen_d = pins.sen_n;
      if (sen_fall)
      begin
         next_spi.cnt = 6'h00;
         next_spi.tx = {rd_data, r.ptr, `FBC_CHIP_ID};
      end
      else if (!pins.sen_n && sck_rise)
      begin
         next_spi.rx = {spi.rx[30:0], pins.sdi};
         next_spi.sdo = spi.tx[31];
         next_spi.tx = {spi.tx[30:0], 1'b0};
         if (spi.cnt != `FBC_CNT_SAT)
            next_spi.cnt = spi.cnt + 6'h01;
      end
      // a full frame for another chip id releases the shared data line
      if (sen_rise && spi.cnt == `FBC_FRAME_BITS)
         next_spi.addressed = (spi.rx[2:0] == `FBC_CHIP_ID);
   end

   // ==========================================================
   // register file
   assign cal_start = wr && (wr_addr == `FBC_ADDR_CAL)
      && (wr_data == 24'h000000) && r.ctrl[`FBC_CTRL_CAL_EN]
      && (cal.state == CAL_IDLE);

   always_comb
   begin
      next_r = r;
      next_bw = bw;
      next_r.otp_wr = 1'b0;
      // the fresh code, not the one left from the previous run
      if (cal_done)
         next_r.fine[3:0] = pick_code;
      if (wr)
      begin
         if (wr_addr == `FBC_ADDR_PTR)
            next_r.ptr = wr_data[4:0];
         else if (wr_addr == `FBC_ADDR_CTRL)
         begin
            next_r.ctrl = wr_data;
            next_r.ctrl[`FBC_CTRL_APPLY] = 1'b0;
            if (wr_data[`FBC_CTRL_APPLY])
            begin
               next_bw.coarse = r.coarse[9:6];
               next_bw.fine = r.fine[3:0];
            end
         end
         else if (wr_addr == `FBC_ADDR_COARSE)
            next_r.coarse = wr_data;
         else if (wr_addr == `FBC_ADDR_FINE)
            next_r.fine = wr_data;
         else if (wr_addr == `FBC_ADDR_PERIOD)
            next_r.period = {9'h000, wr_data[`FBC_PERIOD_MSB:0]};
         else if (wr_addr == `FBC_ADDR_SETTING)
            next_r.setting = {15'h0000, wr_data[`FBC_SETTING_MSB:0]};
         else if (wr_addr == `FBC_ADDR_OTP_MODE)
            next_r.otp_mode = wr_data[0];
         else if (wr_addr == `FBC_ADDR_OTP_ADDR)
            next_r.otp_addr = wr_data[3:0];
         else if (wr_addr == `FBC_ADDR_OTP_STROBE)
            next_r.otp_wr = r.otp_mode && !otp.busy;
      end
      // completion loads the active fine code even beside an apply
      if (cal_done)
         next_bw.fine = pick_code;
      next_bw.corner_mhz = corner_of(next_bw.coarse);
      next_bw.ratio_milli = ratio_of(next_bw.fine);
   end

   // ==========================================================
   // rc calibration sequencer
   // no edge of the reference clock means no progress: the host keeps it
   // running until busy drops
   assign cal_edge = r.ctrl[`FBC_CTRL_DOUBLER]
      ? (pins.cal_ref != cal.cal_ref_d) : (pins.cal_ref && !cal.cal_ref_d);
   assign step = r.ctrl[`FBC_CTRL_DOUBLER] ? {1'b0, r.period[23:1]}
      : r.period;
   assign cal_done = (cal.state == CAL_MEASURE) && pins.trip;

   always_comb
   begin
      next_cal = cal;
      next_cal.cal_ref_d = pins.cal_ref;
      case (cal.state)
         CAL_IDLE:
         begin
            if (cal_start)
            begin
               next_cal.state = CAL_SETTLE;
               next_cal.edges = 9'h000;
               next_cal.acc = 24'h000000;
            end
         end
         CAL_SETTLE:
         begin
            if (cal_edge)
            begin
               next_cal.edges = cal.edges + 9'h001;
               if (cal.edges + 9'h001 >= r.setting[8:0])
                  next_cal.state = CAL_MEASURE;
            end
         end
         CAL_MEASURE:
         begin
            if (pins.trip)
            begin
               next_cal.state = CAL_IDLE;
               next_cal.result = cal.acc;
               next_cal.code = pick_code;
            end
            else if (cal_edge)
            begin
               // saturate so a stuck comparator cannot wrap the count
               if (cal.acc > 24'hFFFFFF - step)
                  next_cal.acc = 24'hFFFFFF;
               else
                  next_cal.acc = cal.acc + step;
            end
         end
         default:
            next_cal.state = CAL_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I)
   begin
      if (RST_I)
      begin
         r <= '0;
         // the synced enable also resets low, so no false fall follows;
         // the rise after it carries no bit count and writes nothing
         spi <= '0;
         cal <= '{state: CAL_IDLE, default: '0};
         bw <= '{corner_mhz: `FBC_BW_RST_CORNER,
            ratio_milli: `FBC_BW_RST_RATIO, default: '0};
      end
      else
      begin
         r <= next_r;
         spi <= next_spi;
         cal <= next_cal;
         bw <= next_bw;
      end
   end

   // ==========================================================
   // outputs
   assign SPI_DATA_O = spi.sdo;
   assign SPI_DATA_OE_O = spi.addressed;
   assign RC_CHARGE_O = (cal.state == CAL_MEASURE);
   assign CLK_DOUBLER_EN_O = r.ctrl[`FBC_CTRL_DOUBLER];
   assign OTP_WRITE_O = r.otp_wr;
   assign OTP_BIT_ADDR_O = r.otp_addr;
   assign BW_O = bw;
   assign CH_I_EN_O = r.ctrl[`FBC_CTRL_CH_I_EN];
   assign CH_Q_EN_O = r.ctrl[`FBC_CTRL_CH_Q_EN];
   assign BIAS_I_EN_O = r.ctrl[`FBC_CTRL_CH_I_EN];
   assign BIAS_Q_EN_O = r.ctrl[`FBC_CTRL_CH_Q_EN];

   // ==========================================================
   // checks
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   sequence apply_write_s;
      wr && wr_addr == `FBC_ADDR_CTRL && wr_data[`FBC_CTRL_APPLY]
         && !cal_done;
   endsequence

   sequence cal_start_s;
      cal_start;
   endsequence

   apply_loads_codes_a:
   assert property (apply_write_s |=> BW_O.coarse == $past(r.coarse[9:6])
      && BW_O.fine == $past(r.fine[3:0]))
   else $error("apply did not load the bandwidth codes");

   codes_hold_a:
   assert property (!(wr && wr_addr == `FBC_ADDR_CTRL) && !cal_done
      |=> $stable(BW_O.coarse) && $stable(BW_O.fine))
   else $error("bandwidth codes changed without apply");

   busy_after_start_a:
   assert property (cal_start_s |=> (cal.state != CAL_IDLE) [*2])
   else $error("busy did not rise after start");

   done_copies_fine_a:
   assert property (cal_done && !(wr && wr_addr == `FBC_ADDR_FINE)
      |=> r.fine[3:0] == cal.code && cal.state == CAL_IDLE
      && BW_O.fine == cal.code)
   else $error("calibration code not copied to fine field");

   host_override_a:
   assert property (wr && wr_addr == `FBC_ADDR_FINE
      |=> r.fine == $past(wr_data))
   else $error("host fine write lost");

   corner_decode_a:
   assert property (BW_O.coarse == 4'h3 |-> BW_O.corner_mhz == 7'h0E)
   else $error("coarse code 3 not 14 MHz");

   ratio_decode_a:
   assert property (BW_O.fine == 4'hB |-> BW_O.ratio_milli == 11'h49F)
   else $error("fine code 11 not ratio 1.183");

   result_readout_a:
   assert property (sen_fall && r.ptr == `FBC_ADDR_RESULT
      |=> spi.tx[31:8] == $past(cal.result))
   else $error("measurement result not loaded for readout");

   stored_codes_a:
   assert property (r.ptr == `FBC_ADDR_CAL && otp.programmed
      |-> rd_data[3:0] == otp.fine && rd_data[9:6] == otp.coarse)
   else $error("stored codes not shown");

   otp_pulse_a:
   assert property (OTP_WRITE_O |=> !OTP_WRITE_O)
   else $error("otp write strobe longer than one cycle");
endmodule

/* File: fbc_host.sv */
// host model: serial master, calibration clock and rc comparator
`timescale 1ns/1ps
module fbc_host #(parameter int TRIP_CYC = 1300)
(
   input wire logic clk_i,
   input wire logic charge_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic sen_n_o,
   output logic sck_o,
   output logic sdi_o,
   output logic cal_ref_o,
   output logic trip_o
);
   // ==========================================================
   // calibration clock and comparator
   logic cal_run = 1'b0;
   // slow: 31.25 MHz reference, else 62.5 MHz
   logic slow = 1'b0;
   logic ck = 1'b0;
   logic tr = 1'b0;
   logic last = 1'b0;
   logic [1:0] ph = 2'h0;
   int chg = 0;
   // released line shows the inverse, never a stale value
   wire line = sdo_oe_i ? sdo_i : ~last;
   assign cal_ref_o = ck;
   assign trip_o = tr;
   initial
   begin
      sen_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
   always @(posedge clk_i)
   begin
      // clock stands still outside a run
      if (cal_run)
      begin
         ph <= ph + 2'h1;
         if (!slow || ph[0])
            ck <= ~ck;
      end
      else
      begin
         ck <= 1'b0;
         ph <= 2'h0;
      end
      chg <= charge_i ? chg + 1 : 0;
      tr <= charge_i && (chg >= TRIP_CYC);
   end
   // ==========================================================
   // one 32-bit frame, msb first; phases of four cycles each
   task automatic frame(input logic [31:0] w, output logic [31:0] r);
      @(posedge clk_i) sen_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int i = 31; i >= 0; i--)
      begin
         sdi_o <= w[i];
         repeat (4) @(posedge clk_i);
         sck_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         sck_o <= 1'b0;
         repeat (3) @(posedge clk_i);
         r[i] = line;
         last = line;
         @(posedge clk_i);
      end
      sen_n_o <= 1'b1;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

/* File: fbc_ctrl_tb.sv */
// self-checking bench for the bandwidth and calibration control
`timescale 1ns/1ps
module fbc_ctrl_tb;
   import fbc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sen_n, sck, sdi, cal_ref, trip, sdo, sdo_oe, charge;
   fbc_otp_t strap = '0;
   fbc_bw_t bw;
   logic dbl_o, otp_wr, ch_i, ch_q, bias_i, bias_q;
   logic [3:0] otp_a;
   int n_errors = 0;
   int checks = 0;
   int npulse = 0;
   int crn[9] = '{5, 7, 10, 14, 20, 28, 40, 50, 72};
   int rat[12] = '{803, 832, 862, 893, 926, 959, 994, 1030, 1063, 1097,
      1136, 1183};
   int mx[11] = '{818, 846, 878, 909, 943, 976, 1012, 1048, 1078, 1116,
      1155};
   always #4 clk = ~clk;
   always @(posedge clk)
      if (otp_wr === 1'b1)
         npulse++;
   // ==========================================================
   // design and host model
   fbc_ctrl dut_u (.REF_CLK_I(clk), .RST_I(rst), .SPI_EN_N_I(sen_n),
      .SPI_CLK_I(sck), .SPI_DATA_I(sdi), .SPI_DATA_O(sdo),
      .SPI_DATA_OE_O(sdo_oe), .CALIBRATION_REFERENCE_CLOCK_I(cal_ref),
      .RC_TRIP_I(trip), .RC_CHARGE_O(charge), .CLK_DOUBLER_EN_O(dbl_o),
      .OTP_STRAP_I(strap), .OTP_WRITE_O(otp_wr), .OTP_BIT_ADDR_O(otp_a),
      .BW_O(bw), .CH_I_EN_O(ch_i), .CH_Q_EN_O(ch_q),
      .BIAS_I_EN_O(bias_i), .BIAS_Q_EN_O(bias_q));
   fbc_host host_u (.clk_i(clk), .charge_i(charge), .sdo_i(sdo),
      .sdo_oe_i(sdo_oe), .sen_n_o(sen_n), .sck_o(sck), .sdi_o(sdi),
      .cal_ref_o(cal_ref), .trip_o(trip));
   // ==========================================================
   // shared helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      logic [31:0] r;
      host_u.frame({d, a, 3'b101}, r);
   endtask
   // pointer frame first, data comes back on the second
   task automatic rd(input logic [4:0] a, output logic [23:0] d);
      logic [31:0] r;
      wr(5'h00, {19'h0, a});
      host_u.frame({19'h0, a, 5'h00, 3'b101}, r);
      d = r[31:8];
   endtask
   task automatic close_out;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_decode;
      int c;
      for (int i = 0; i < 12; i++)
      begin
         c = (i > 8) ? 8 : i;
         wr(5'h02, 24'(c << 6));
         wr(5'h03, 24'(i));
         chk(bw.fine, (i == 0) ? 0 : i - 1);
         wr(5'h01, 24'h000010);
         chk(bw.coarse, c);
         chk(bw.corner_mhz, crn[c]);
         chk(bw.ratio_milli, rat[i]);
      end
   endtask
   task automatic t_regs;
      logic [23:0] d;
      logic [31:0] r;
      strap <= '{programmed: 1'b1, busy: 1'b0, coarse: 4'h6, fine: 4'h2};
      rd(5'h04, d);
      chk(d[9:6], 4'h6);
      chk(d[3:0], 4'h2);
      strap <= '0;
      rd(5'h1F, d);
      chk(d, 24'h000000);
      // foreign chip id: no write, and the data line is let go
      host_u.frame({24'h000040, 5'h02, 3'b011}, r);
      chk(sdo_oe, 1'b0);
      rd(5'h02, d);
      chk(d, 24'h000200);
   endtask
   task automatic t_cal(input logic dbl);
      logic [23:0] d, res;
      int ex;
      wr(5'h01, 24'h0000C0);
      wr(5'h04, 24'h000000);
      rd(5'h08, d);
      chk(d[4], 1'b0);
      chk({bias_i, bias_q, ch_i, ch_q}, 4'hF);
      wr(5'h01, 24'h0000C2 | {21'h0, dbl, 2'h0});
      chk(dbl_o, dbl);
      // a slow reference runs with the doubler, a fast one without
      wr(5'h05, dbl ? 24'd32000 : 24'd16000);
      wr(5'h06, 24'd152);
      host_u.slow <= dbl;
      host_u.cal_run <= 1'b1;
      wr(5'h04, 24'h000000);
      rd(5'h08, d);
      chk(d[4], 1'b1);
      for (int n = 0; n < 20 && d[4] !== 1'b0; n++)
         rd(5'h08, d);
      chk(d[4], 1'b0);
      host_u.cal_run <= 1'b0;
      rd(5'h09, res);
      chk(res >= 24'd10240000 && res <= 24'd10560000, 1);
      ex = 0;
      foreach (mx[k])
         if (res >= mx[k] * 10370 - 153600)
            ex++;
      chk(d[3:0], ex);
      chk(bw.fine, ex);
      rd(5'h03, d);
      chk(d[3:0], ex);
      wr(5'h03, 24'h000003);
      wr(5'h01, 24'h000010);
      chk(bw.fine, 4'h3);
      rd(5'h03, d);
      chk(d[3:0], 4'h3);
   endtask
   task automatic t_otp;
      int p;
      wr(5'h0B, 24'h000001);
      wr(5'h0C, 24'h000009);
      chk(otp_a, 4'h9);
      p = npulse;
      wr(5'h0D, 24'h000000);
      chk(npulse, p + 1);
      wr(5'h0B, 24'h000000);
      wr(5'h0D, 24'h000000);
      chk(npulse, p + 1);
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(bw.corner_mhz, 5);
      chk(bw.ratio_milli, 803);
      chk(sdo_oe, 1'b0);
      t_decode();
      t_regs();
      t_cal(1'b0);
      t_cal(1'b1);
      t_otp();
      close_out();
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      n_errors++;
      close_out();
   end
endmodule
